// *** design/rolling_average_limit_power.sv ***
// Rolling average filter, window alert and power mode control of a dual converter.
module rolling_average_limit_power (
  input  wire logic                                            ref_clk,
  input  wire logic                                            nrst,
  input  wire logic                                            link_clk,
  input  wire logic                                            cfg_wr,
  input  wire rolling_average_limit_power_pkg::cfg_write_t     cfg_in,
  input  wire logic                                            cs_n,
  input  wire rolling_average_limit_power_pkg::limits_t        limits,
  input  wire logic                                            conv_done,
  input  wire logic [rolling_average_limit_power_pkg::SAMPLE_W-1:0] conv_a,
  input  wire logic [rolling_average_limit_power_pkg::SAMPLE_W-1:0] conv_b,
  output logic                                                 conv_start,
  output logic                                                 pair_select,
  output rolling_average_limit_power_pkg::result_t             result,
  output logic                                                 result_valid,
  output rolling_average_limit_power_pkg::alert_flags_t        alert_status,
  output logic                                                 flag_pin_n,
  output logic                                                 flag_pin_oe,
  output logic                                                 analog_off,
  output logic                                                 reference_off,
  output rolling_average_limit_power_pkg::cfg_t                active_cfg
);

  // Link side: holding word plus event toggle
  typedef struct packed {
    logic                                        rst_meta;
    logic                                        rst_sync;
    logic                                        tog;
    rolling_average_limit_power_pkg::cfg_write_t hold;
  } link_state_t;

  // Core side: everything on ref_clk
  typedef struct packed {
    logic                                          cs_meta;
    logic                                          cs_sync;
    logic                                          cs_prev;
    logic                                          tog_meta;
    logic                                          tog_sync;
    logic                                          tog_prev;
    rolling_average_limit_power_pkg::cfg_t         active;
    rolling_average_limit_power_pkg::cfg_t         pending;
    rolling_average_limit_power_pkg::latency_state_t lat;
    logic                                          fill_pending;
    logic                                          pair;
    logic                                          pair_out;
    rolling_average_limit_power_pkg::store_t       store_a;
    rolling_average_limit_power_pkg::store_t       store_b;
    rolling_average_limit_power_pkg::result_t      res;
    logic                                          res_valid;
    rolling_average_limit_power_pkg::alert_flags_t flags;
    logic                                          flag_pin_n;
    logic                                          conv_start;
  } core_state_t;

  link_state_t link_ff;
  link_state_t nxt_link;
  core_state_t core_ff;
  core_state_t nxt_core;

  // Link domain: capture a write and flip the toggle
  always_comb
  begin
    nxt_link          = link_ff;
    nxt_link.rst_meta = nrst;
    nxt_link.rst_sync = link_ff.rst_meta;
    if (!link_ff.rst_sync)
    begin
      nxt_link.tog  = 1'b0;
      nxt_link.hold = '0;
    end
    else if (cfg_wr)
    begin
      nxt_link.hold = cfg_in;
      nxt_link.tog  = ~link_ff.tog;
    end
  end

  // Reset reaches the link side through its own two stages
  always_ff @(posedge link_clk)
  begin
    link_ff <= nxt_link;
  end

  // Core domain: sequencer, store, averaging, alert, power
  always_comb
  begin
    logic                                          cs_fall;
    logic                                          wr_seen;
    logic                                          sw_reset;
    rolling_average_limit_power_pkg::cfg_t         wcfg;
    rolling_average_limit_power_pkg::store_t       sa;
    rolling_average_limit_power_pkg::store_t       sb;
    logic [rolling_average_limit_power_pkg::BOOST_W-1:0] ra;
    logic [rolling_average_limit_power_pkg::BOOST_W-1:0] rb;
    logic [rolling_average_limit_power_pkg::SAMPLE_W-1:0] cmp_a;
    logic [rolling_average_limit_power_pkg::SAMPLE_W-1:0] cmp_b;
    rolling_average_limit_power_pkg::alert_flags_t fl;
    cs_fall  = 1'b0;
    wr_seen  = 1'b0;
    sw_reset = 1'b0;
    wcfg     = link_ff.hold.cfg;
    sa       = '0;
    sb       = '0;
    ra       = '0;
    rb       = '0;
    cmp_a    = '0;
    cmp_b    = '0;
    fl       = '0;

    nxt_core            = core_ff;
    nxt_core.cs_meta    = cs_n;
    nxt_core.cs_sync    = core_ff.cs_meta;
    nxt_core.cs_prev    = core_ff.cs_sync;
    nxt_core.tog_meta   = link_ff.tog;
    nxt_core.tog_sync   = core_ff.tog_meta;
    nxt_core.tog_prev   = core_ff.tog_sync;
    nxt_core.conv_start = 1'b0;
    nxt_core.res_valid  = 1'b0;

    cs_fall = core_ff.cs_prev && !core_ff.cs_sync;
    wr_seen = core_ff.tog_prev ^ core_ff.tog_sync;

    // Chip-select fall: start conversion, step sequencer and latency
    if (cs_fall)
    begin
      nxt_core.flag_pin_n = 1'b1; // R20
      if (!core_ff.active.sleep_select) // R22
      begin
        nxt_core.conv_start = 1'b1; // R8
        if (core_ff.active.channel_alternation_enable)
        begin
          nxt_core.pair_out = core_ff.pair; // R25
          nxt_core.pair     = ~core_ff.pair; // R25
        end
        else
          nxt_core.pair_out = core_ff.active.manual_pair_select;
      end
      case (core_ff.lat)
        rolling_average_limit_power_pkg::LAT_WAIT2:
          nxt_core.lat = rolling_average_limit_power_pkg::LAT_WAIT1; // R12
        rolling_average_limit_power_pkg::LAT_WAIT1:
        begin
          nxt_core.lat    = rolling_average_limit_power_pkg::LAT_IDLE; // R12
          nxt_core.active = core_ff.pending;
          if (!core_ff.active.channel_alternation_enable)
            nxt_core.pair = 1'b0; // R25
          if (core_ff.pending.reference_source_select
              != core_ff.active.reference_source_select)
            nxt_core.fill_pending = 1'b1; // R6
        end
        default:
          nxt_core.lat = rolling_average_limit_power_pkg::LAT_IDLE;
      endcase
    end

    // Configuration write arriving from the link side
    if (wr_seen)
    begin
      sw_reset = link_ff.hold.soft_reset || link_ff.hold.hard_reset;
      if (sw_reset)
      begin
        nxt_core.lat          = rolling_average_limit_power_pkg::LAT_IDLE; // R26
        nxt_core.fill_pending = 1'b1; // R6
        nxt_core.pair         = 1'b0; // R26
        nxt_core.flags        = '0; // R20
        nxt_core.flag_pin_n   = 1'b1;
        nxt_core.res          = '0; // R26
        if (link_ff.hold.hard_reset)
        begin
          nxt_core.active  = rolling_average_limit_power_pkg::cfg_t'(
                               rolling_average_limit_power_pkg::CFG_DEFAULT); // R26
          nxt_core.pending = rolling_average_limit_power_pkg::cfg_t'(
                               rolling_average_limit_power_pkg::CFG_DEFAULT); // R26
        end
      end
      else if (wcfg.channel_alternation_enable
               && rolling_average_limit_power_pkg::avg_active(wcfg))
      begin
        // Sequenced averaging takes effect two conversions later
        nxt_core.pending = wcfg; // R12
        nxt_core.lat     = rolling_average_limit_power_pkg::LAT_WAIT2; // R12
      end
      else
      begin
        // Sleep comes with the whole word; other settings take the written values
        nxt_core.active = wcfg; // R23
        nxt_core.lat    = rolling_average_limit_power_pkg::LAT_IDLE;
        if (!wcfg.channel_alternation_enable)
          nxt_core.pair = 1'b0; // R25
        if (wcfg.reference_source_select != core_ff.active.reference_source_select)
          nxt_core.fill_pending = 1'b1; // R6
      end
    end

    // Conversion end: shift store, average, check limits
    if (conv_done && !core_ff.active.sleep_select)
    begin
      if (core_ff.fill_pending)
      begin
        for (int i = 0; i < rolling_average_limit_power_pkg::STORE_DEPTH; i++)
        begin
          sa[i] = conv_a; // R6
          sb[i] = conv_b; // R6
        end
        nxt_core.fill_pending = 1'b0;
      end
      else
      begin
        // Shift happens whatever the ratio, so ratio changes need no refill
        sa = {core_ff.store_a[rolling_average_limit_power_pkg::STORE_DEPTH-2:0],
              conv_a}; // R7
        sb = {core_ff.store_b[rolling_average_limit_power_pkg::STORE_DEPTH-2:0],
              conv_b}; // R7
      end
      nxt_core.store_a = sa; // R5
      nxt_core.store_b = sb; // R5
      ra = rolling_average_limit_power_pkg::average(sa, core_ff.active); // R3
      rb = rolling_average_limit_power_pkg::average(sb, core_ff.active); // R4
      nxt_core.res.a     = ra;
      nxt_core.res.b     = rb;
      nxt_core.res.width = (core_ff.active.extra_bits_enable
                            && rolling_average_limit_power_pkg::avg_active(core_ff.active))
                           ? rolling_average_limit_power_pkg::WIDTH_BOOSTED
                           : rolling_average_limit_power_pkg::WIDTH_PLAIN; // R13
      nxt_core.res_valid = 1'b1; // R4
      // Limits are 16-bit, so a boosted result is compared at 16 bits
      if (nxt_core.res.width == rolling_average_limit_power_pkg::WIDTH_BOOSTED)
      begin
        cmp_a = ra[rolling_average_limit_power_pkg::BOOST_W-1:
                   rolling_average_limit_power_pkg::BOOST_SHIFT];
        cmp_b = rb[rolling_average_limit_power_pkg::BOOST_W-1:
                   rolling_average_limit_power_pkg::BOOST_SHIFT];
      end
      else
      begin
        cmp_a = ra[rolling_average_limit_power_pkg::SAMPLE_W-1:0]; // R17
        cmp_b = rb[rolling_average_limit_power_pkg::SAMPLE_W-1:0]; // R17
      end
      fl.a_high = cmp_a > limits.upper; // R14
      fl.a_low  = cmp_a < limits.lower; // R14
      fl.b_high = cmp_b > limits.upper; // R15
      fl.b_low  = cmp_b < limits.lower; // R15
      // Overwrite, set after any same-cycle reset clear so the event wins
      nxt_core.flags = fl; // R18
      if (core_ff.active.output_lane_select && core_ff.active.alert_pin_enable)
        nxt_core.flag_pin_n = ~(|fl); // R16
      else
        nxt_core.flag_pin_n = 1'b1;
    end
  end

  // Core registers; power-on and hard reset share defaults
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      core_ff              <= '0;
      core_ff.cs_meta      <= 1'b1;
      core_ff.cs_sync      <= 1'b1;
      core_ff.cs_prev      <= 1'b1;
      core_ff.active       <= rolling_average_limit_power_pkg::cfg_t'(
                                rolling_average_limit_power_pkg::CFG_DEFAULT);
      core_ff.pending      <= rolling_average_limit_power_pkg::cfg_t'(
                                rolling_average_limit_power_pkg::CFG_DEFAULT);
      core_ff.lat          <= rolling_average_limit_power_pkg::LAT_IDLE;
      core_ff.fill_pending <= 1'b1;
      core_ff.flag_pin_n   <= 1'b1;
    end
    else
      core_ff <= nxt_core;
  end

  // Outputs from core flops; flag_pin_oe and reference_off each gate two flop bits
  assign conv_start    = core_ff.conv_start;
  assign pair_select   = core_ff.pair_out;
  assign result        = core_ff.res;
  assign result_valid  = core_ff.res_valid;
  assign alert_status  = core_ff.flags;
  assign flag_pin_n    = core_ff.flag_pin_n;
  assign flag_pin_oe   = core_ff.active.output_lane_select
                         && core_ff.active.alert_pin_enable; // R16
  assign analog_off    = core_ff.active.sleep_select; // R21
  assign reference_off = core_ff.active.sleep_select
                         && !core_ff.active.reference_source_select; // R22
  assign active_cfg    = core_ff.active;

endmodule : rolling_average_limit_power

// *** design/rolling_average_limit_power_pkg.sv ***
// Constants, types and shared functions for the rolling average, limit and power block.
// Operation
// R1: Averaging needs enable bit and nonzero ratio
// R2: Host disables with enable and ratio zero
// R3: Output is sum of recent n over n
// R4: Sliding store keeps output rate at throughput
// R5: Store holds eight samples per converter
// R6: First conversion after resets fills whole store
// R7: Every conversion shifts into store regardless
// R8: Conversions start on chip-select falling edge
// R9: Plain averaged result is sixteen bits
// R10: Ratio codes 1,2,3 give 2,4,8; else 8
// R11: Host sets ratio, enable, alternation together
// R12: Sequenced averaging applies after two conversions
// R13: Extra bits with averaging give 18-bit result
// R14: Alert when above upper or below lower
// R15: Two alert flags per converter
// R16: OR of flags drives low flag pin
// R17: Limit check works with or without averaging
// R18: Conversion end updates flag pin and flags
// R19: Host reads flags before next conversion
// R20: Chip-select fall clears pin; reset clears flags
// R21: Sleep select zero normal, one power-down
// R22: Power-down turns analog and reference off; reference_off is set only with reference_source_select zero
// R23: Power-down keeps configuration values
// R24: Host waits for turn-on before converting
// R25: Sequencer starts first pair, alternates, ignores manual
// R26: Soft reset flushes; hard reset restores defaults
// R27: Average truncates by right shift log2 n
package rolling_average_limit_power_pkg;

  localparam int          SAMPLE_W        = 16;
  localparam int          BOOST_W         = 18;
  localparam int          STORE_DEPTH     = 8;
  localparam int          SUM_W           = 19;
  localparam int          BOOST_SHIFT     = 2;
  localparam logic [4:0]  WIDTH_PLAIN     = 5'h10;
  localparam logic [4:0]  WIDTH_BOOSTED   = 5'h12;
  localparam logic [2:0]  RATIO_OFF       = 3'h0;
  localparam logic [10:0] CFG_DEFAULT     = 11'h000;
  localparam logic [15:0] SAMPLE_ZERO     = 16'h0000;
  localparam int          REF_CLK_NS      = 8;

  // Configuration bits as one word
  typedef struct packed {
    logic       sleep_select;
    logic       alert_pin_enable;
    logic       output_lane_select;
    logic       manual_pair_select;
    logic       channel_alternation_enable;
    logic       reference_source_select;
    logic       extra_bits_enable;
    logic       averaging_enable;
    logic [2:0] average_ratio_code;
  } cfg_t;

  // One configuration write with its reset requests
  typedef struct packed {
    cfg_t cfg;
    logic soft_reset;
    logic hard_reset;
  } cfg_write_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] upper;
    logic [SAMPLE_W-1:0] lower;
  } limits_t;

  typedef struct packed {
    logic [BOOST_W-1:0] a;
    logic [BOOST_W-1:0] b;
    logic [4:0]         width;
  } result_t;

  typedef struct packed {
    logic a_high;
    logic a_low;
    logic b_high;
    logic b_low;
  } alert_flags_t;

  typedef logic [STORE_DEPTH-1:0][SAMPLE_W-1:0] store_t;

  // Path idle -> wait two -> wait one -> idle; one bit flips per step except wait one -> idle
  typedef enum logic [1:0] {
    LAT_IDLE  = 2'h0,
    LAT_WAIT2 = 2'h1,
    LAT_WAIT1 = 2'h3
  } latency_state_t;

  // Averaging is live only with enable and a nonzero ratio
  function automatic logic avg_active(input cfg_t c);
    avg_active = c.averaging_enable && (c.average_ratio_code != RATIO_OFF); // R1
  endfunction : avg_active

  // Shift equals log2 of the sample count
  function automatic logic [1:0] ratio_shift(input logic [2:0] code);
    case (code)
      3'h1:    ratio_shift = 2'h1; // R10
      3'h2:    ratio_shift = 2'h2; // R10
      default: ratio_shift = 2'h3; // R10
    endcase
  endfunction : ratio_shift

  // Average of the newest n entries, entry 0 newest
  function automatic logic [BOOST_W-1:0] average(input store_t st, input cfg_t c);
    logic [SUM_W-1:0]   sum;
    logic [SUM_W+1:0]   wide;
    logic [1:0]         sh;
    logic [3:0]         n;
    sum  = '0;
    wide = '0;
    sh   = ratio_shift(c.average_ratio_code);
    n    = 4'(1) << sh;
    for (int i = 0; i < STORE_DEPTH; i++)
    begin
      if (4'(i) < n)
        sum = sum + SUM_W'(st[i]); // R3
    end
    if (!avg_active(c))
      average = {2'b00, st[0]};
    else if (c.extra_bits_enable)
    begin
      wide    = {sum, 2'b00} >> sh; // R13
      average = wide[BOOST_W-1:0];
    end
    else
    begin
      wide    = {2'b00, sum} >> sh; // R27
      average = {2'b00, wide[SAMPLE_W-1:0]}; // R9
    end
  endfunction : average

endpackage : rolling_average_limit_power_pkg

// *** bench/rolling_average_limit_power_chk.sv ***
// Port-level assertions for the rolling average, limit and power block.
module rolling_average_limit_power_chk (
  input wire logic                                       ref_clk,
  input wire logic                                       nrst,
  input wire logic                                       cs_n,
  input wire rolling_average_limit_power_pkg::limits_t   limits,
  input wire logic                                       conv_done,
  input wire logic                                       conv_start,
  input wire rolling_average_limit_power_pkg::result_t   result,
  input wire logic                                       result_valid,
  input wire rolling_average_limit_power_pkg::alert_flags_t alert_status,
  input wire logic                                       flag_pin_n,
  input wire logic                                       flag_pin_oe,
  input wire logic                                       analog_off,
  input wire logic                                       reference_off,
  input wire rolling_average_limit_power_pkg::cfg_t      active_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic        boost;

  // Compared value drops the two extra bits when boosted
  assign boost = active_cfg.averaging_enable && (active_cfg.average_ratio_code != 3'h0)
                 && active_cfg.extra_bits_enable;
  assign cmp_a = (result.width == 5'h12) ? result.a[17:2] : result.a[15:0];
  assign cmp_b = (result.width == 5'h12) ? result.b[17:2] : result.b[15:0];

  // Chip-select fall, then a start through the synchroniser
  sequence s_cs_fall;
    $fell(cs_n) ##0 !active_cfg.sleep_select;
  endsequence
  sequence s_start;
    ##[2:5] conv_start;
  endsequence

  a_cs_start: assert property (s_cs_fall |-> s_start)
    else $error("no conversion start after chip select fall");
  a_start_once: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_start_pin: assert property (conv_start |-> flag_pin_n)
    else $error("flag pin not cleared at conversion start");
  a_sleep_idle: assert property (
    active_cfg.sleep_select && $past(active_cfg.sleep_select, 4) |-> !conv_start)
    else $error("conversion started while asleep");
  a_done_result: assert property (conv_done && !active_cfg.sleep_select |=> result_valid)
    else $error("no result after conversion end");
  a_valid_cause: assert property (result_valid |-> $past(conv_done))
    else $error("result without conversion end");
  a_width_mode: assert property (result_valid |-> result.width == (boost ? 5'h12 : 5'h10))
    else $error("result width wrong for mode");
  a_alert_a: assert property (
    result_valid |-> alert_status.a_high == (cmp_a > limits.upper)
    && alert_status.a_low == (cmp_a < limits.lower))
    else $error("converter a flags wrong");
  a_alert_b: assert property (
    result_valid |-> alert_status.b_high == (cmp_b > limits.upper)
    && alert_status.b_low == (cmp_b < limits.lower))
    else $error("converter b flags wrong");
  a_pin_or: assert property (result_valid && flag_pin_oe |-> flag_pin_n == !(|alert_status))
    else $error("flag pin not the OR of the flags");
  a_oe_cfg: assert property (
    flag_pin_oe == (active_cfg.output_lane_select && active_cfg.alert_pin_enable))
    else $error("flag pin enable wrong");
  a_power_off: assert property (
    analog_off == active_cfg.sleep_select && reference_off ==
    (active_cfg.sleep_select && !active_cfg.reference_source_select))
    else $error("power-down outputs wrong");
endmodule : rolling_average_limit_power_chk

bind rolling_average_limit_power rolling_average_limit_power_chk chk_inst (.ref_clk, .nrst,
  .cs_n, .limits, .conv_done, .conv_start, .result, .result_valid, .alert_status,
  .flag_pin_n, .flag_pin_oe, .analog_off, .reference_off, .active_cfg);

// *** bench/conv_core_model.sv ***
// Behavioural model of the analog converter core behind the block.
module conv_core_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        conv_start,
  input  wire logic        slow,
  input  wire logic [15:0] a_val,
  input  wire logic [15:0] b_val,
  output logic             conv_done,
  output logic [15:0]      conv_a,
  output logic [15:0]      conv_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cnt_ff;
  logic [15:0] hold_a_ff;
  logic [15:0] hold_b_ff;

  // Sample held at start; data lines invert once the done cycle passes
  always_ff @(posedge ref_clk)
  begin
    conv_done <= 1'b0;
    if (!nrst)
    begin
      cnt_ff <= 4'h0;
      conv_a <= 16'h0000;
      conv_b <= 16'h0000;
    end
    else if (conv_start)
    begin
      cnt_ff    <= slow ? 4'h9 : 4'h2;
      hold_a_ff <= a_val;
      hold_b_ff <= b_val;
    end
    else if (cnt_ff == 4'h1)
    begin
      cnt_ff    <= 4'h0;
      conv_done <= 1'b1;
      conv_a    <= hold_a_ff;
      conv_b    <= hold_b_ff;
    end
    else
    begin
      if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
      if (conv_done)
      begin
        conv_a <= ~conv_a;
        conv_b <= ~conv_b;
      end
    end
  end
endmodule : conv_core_model

// *** bench/testbench.sv ***
// Self-checking bench for the rolling average, limit and power block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr = 1'b0;
  logic cs_n = 1'b1;
  logic slow = 1'b0;
  logic fill = 1'b1;
  logic pn = 1'b0;
  logic [15:0] a_val = 16'h0000;
  logic [15:0] b_val = 16'h0000;
  logic [15:0] rnd = 16'h0025;
  logic conv_done, conv_start, pair_select, result_valid;
  logic flag_pin_n, flag_pin_oe, analog_off, reference_off;
  logic [15:0] conv_a, conv_b;
  rolling_average_limit_power_pkg::cfg_write_t   cfg_in = '0;
  rolling_average_limit_power_pkg::limits_t      limits = {16'hA000, 16'h4000};
  rolling_average_limit_power_pkg::result_t      result;
  rolling_average_limit_power_pkg::alert_flags_t alert_status;
  rolling_average_limit_power_pkg::cfg_t         active_cfg, cur, pend;
  int lat = 0;
  int err_total = 0;
  int n_compared = 0;
  int sa[$];
  int sb[$];

  // Core clock, and a link clock with an unrelated phase
  always #4 ref_clk = ~ref_clk;
  initial
  begin
    #13;
    forever #80 link_clk = ~link_clk;
  end

  rolling_average_limit_power rolling_average_limit_power_inst (.ref_clk, .nrst, .link_clk,
    .cfg_wr, .cfg_in, .cs_n, .limits, .conv_done, .conv_a, .conv_b, .conv_start, .pair_select,
    .result, .result_valid, .alert_status, .flag_pin_n, .flag_pin_oe, .analog_off,
    .reference_off, .active_cfg);
  conv_core_model conv_core_model_inst (.ref_clk, .nrst, .conv_start, .slow, .a_val, .b_val,
    .conv_done, .conv_a, .conv_b);

  task automatic chk(input logic [40:0] seen, input logic [40:0] want);
    n_compared++;
    if (seen !== want)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task automatic complete_run;
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return v[0] ? ((v >> 1) ^ 16'hB400) : (v >> 1);
  endfunction : lfsr

  // Reference average from the newest entries
  function automatic logic [17:0] avg(input int q[$], input rolling_average_limit_power_pkg::cfg_t c);
    int n;
    int sum;
    n = (c.average_ratio_code == 3'h1) ? 2 : (c.average_ratio_code == 3'h2) ? 4 : 8;
    sum = 0;
    for (int i = 0; i < n; i++)
      sum += q[i];
    if (!(c.averaging_enable && c.average_ratio_code != 3'h0))
      return 18'(q[0]);
    if (c.extra_bits_enable)
      return 18'((sum * 4) / n);
    return 18'(sum / n);
  endfunction : avg

  function automatic logic [1:0] flags(input logic [17:0] v, input logic bst);
    logic [15:0] cv;
    cv = bst ? v[17:2] : v[15:0];
    return {cv > limits.upper, cv < limits.lower};
  endfunction : flags

  // One link write, then the mirror of the configuration follows
  task automatic wr(input rolling_average_limit_power_pkg::cfg_t c, input logic s, input logic h);
    @(negedge link_clk);
    cfg_in = {c, s, h};
    cfg_wr = 1'b1;
    @(negedge link_clk);
    cfg_wr = 1'b0;
    repeat (3) @(negedge link_clk);
    if (h)
      cur = '0;
    else if (!s)
    begin
      fill |= (c.reference_source_select !== cur.reference_source_select);
      if (c.channel_alternation_enable && !cur.channel_alternation_enable)
        pn = 1'b0;
      if (c.channel_alternation_enable && c.averaging_enable && c.average_ratio_code != 3'h0)
        lat = 2;
      else
        cur = c;
      pend = c;
    end
    if (s || h)
    begin
      fill = 1'b1;
      pn = 1'b0;
      chk(alert_status, 0);
    end
    chk(active_cfg, cur);
    chk({analog_off, reference_off, flag_pin_oe}, {cur.sleep_select, cur.sleep_select
        && !cur.reference_source_select, cur.output_lane_select && cur.alert_pin_enable});
  endtask : wr

  // Chip-select frame with random samples; flags read before the next one
  task automatic conv;
    int k;
    logic got;
    logic bst;
    logic [17:0] ea;
    logic [17:0] eb;
    logic [3:0]  ef;
    @(negedge ref_clk);
    rnd = lfsr(rnd);
    a_val = rnd;
    rnd = lfsr(rnd);
    b_val = rnd;
    slow = rnd[3];
    cs_n = 1'b0;
    for (k = 0; k < 8 && conv_start !== 1'b1; k++)
      @(negedge ref_clk);
    if (lat == 1)
      cur = pend;
    if (lat > 0)
      lat--;
    chk(conv_start, !cur.sleep_select);
    chk(flag_pin_n, 1'b1);
    if (!cur.sleep_select)
    begin
      chk(pair_select, cur.channel_alternation_enable ? pn : cur.manual_pair_select);
      pn = ~pn;
    end
    got = 1'b0;
    for (k = 0; k < 30 && !got; k++)
    begin
      @(negedge ref_clk);
      got = (result_valid === 1'b1);
    end
    cs_n = 1'b1;
    chk(got, !cur.sleep_select);
    if (got)
    begin
      repeat (fill ? 8 : 1)
      begin
        sa.push_front(a_val);
        sb.push_front(b_val);
      end
      fill = 1'b0;
      while (sa.size() > 8)
      begin
        void'(sa.pop_back());
        void'(sb.pop_back());
      end
      bst = cur.averaging_enable && cur.average_ratio_code != 3'h0 && cur.extra_bits_enable;
      ea = avg(sa, cur);
      eb = avg(sb, cur);
      chk(result, {ea, eb, bst ? 5'h12 : 5'h10});
      ef = {flags(ea, bst), flags(eb, bst)};
      chk(alert_status, ef);
      chk(flag_pin_n, !(cur.output_lane_select && cur.alert_pin_enable && |ef));
    end
    repeat (3) @(negedge ref_clk);
  endtask : conv

  // Main sequence: every ratio code with and without extra bits, averaging off for code 5 with extra bits
  initial
  begin
    rolling_average_limit_power_pkg::cfg_t c;
    cur = '0;
    repeat (3) @(negedge link_clk);
    nrst = 1'b1;
    repeat (4) @(negedge link_clk);
    chk({active_cfg, alert_status, flag_pin_n}, {11'h000, 4'h0, 1'b1});
    repeat (2) conv();
    for (int i = 0; i < 16; i++)
    begin
      c = '0;
      c.average_ratio_code = i[2:0];
      c.averaging_enable = (i != 13);
      c.extra_bits_enable = i[3];
      c.reference_source_select = i[2];
      c.manual_pair_select = i[1];
      c.output_lane_select = 1'b1;
      c.alert_pin_enable = i[0] | i[3];
      wr(c, 1'b0, 1'b0);
      repeat (3) conv();
    end
    c = '0;
    wr(c, 1'b0, 1'b0);
    c.channel_alternation_enable = 1'b1;
    c.manual_pair_select = 1'b1;
    wr(c, 1'b0, 1'b0);
    repeat (4) conv();
    c.average_ratio_code = 3'h2;
    c.averaging_enable = 1'b1;
    wr(c, 1'b0, 1'b0);
    repeat (3) conv();
    c.averaging_enable = 1'b0;
    c.sleep_select = 1'b1;
    wr(c, 1'b0, 1'b0);
    conv();
    c.sleep_select = 1'b0;
    wr(c, 1'b0, 1'b0);
    repeat (20) @(negedge ref_clk);
    conv();
    wr(c, 1'b1, 1'b0);
    conv();
    wr(c, 1'b0, 1'b1);
    conv();
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule : testbench
